// File: rtl/sbpt_pkg.sv
// Purpose: shared constants, types and lookups for the bus phase timer
// Assumes: 40 MHz core clock, every bus pin sampled through two flops
// Notes:   minimum delays round up, maximum delays round down
package sbpt_pkg;

	// ************************************************************
	// clock
	// ************************************************************
	localparam int CLK_NS = 25;                // core clock period
	localparam int CLK_HZ = 40_000_000;        // core clock rate

	// ************************************************************
	// short bus delays, printed figures and derived cycle counts
	// ************************************************************
	localparam int ARB_DELAY_NS   = 2400;      // min, before arbitration sample
	localparam int SETTLE_NS      = 400;       // min, idle before bus free
	localparam int BUS_CLEAR_NS   = 800;       // max, release after trigger
	localparam int FREE_REL_NS    = 1200;      // max, release after idle start
	localparam int BUS_FREE_NS    = 800;       // min, free to arbitration
	localparam int BUS_SET_NS     = 1600;      // max, free to arbitration
	localparam int DATA_REL_NS    = 400;       // max, data off after i/o rise
	localparam int RESET_HOLD_NS  = 25000;     // min, reset drive length

	localparam int ARB_CYC        = (ARB_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUS_CLEAR_CYC  = BUS_CLEAR_NS / CLK_NS;
	localparam int FREE_REL_CYC   = FREE_REL_NS / CLK_NS;
	localparam int BUS_FREE_CYC   = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUS_SET_CYC    = BUS_SET_NS / CLK_NS;
	localparam int DATA_REL_CYC   = DATA_REL_NS / CLK_NS;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;

	// ************************************************************
	// long delays, defaults of the top-level parameters
	// ************************************************************
	localparam int DISC_US        = 200;       // min, disconnect to arbitration
	localparam int SEL_ABORT_US   = 200;       // max, selected to bsy answer
	localparam int SEL_TMO_MS     = 250;       // min, wait for bsy answer
	localparam int POWER_ON_S     = 10;        // power-up answer deadline
	localparam int RESET_SEL_MS   = 250;       // bus reset answer deadline

	localparam int DISC_CYC       = DISC_US * (CLK_HZ / 1_000_000);
	localparam int SEL_ABORT_CYC  = SEL_ABORT_US * (CLK_HZ / 1_000_000);
	localparam int SEL_TMO_CYC    = SEL_TMO_MS * (CLK_HZ / 1000);
	localparam int POWER_ON_CYC   = POWER_ON_S * CLK_HZ;
	localparam int RESET_SEL_CYC  = RESET_SEL_MS * (CLK_HZ / 1000);

	// ************************************************************
	// synchronous transfer periods
	// ************************************************************
	localparam int FAST5_NS       = 200;
	localparam int FAST10_NS      = 100;
	localparam int FAST20_NS      = 50;
	localparam int FAST40_NS      = 25;
	localparam int FAST80_NS      = 25;

	// ************************************************************
	// widths, indices, reset values
	// ************************************************************
	localparam int CNT_W          = 8;         // phase and gap counters
	localparam int TMR_W          = 32;        // long delay timers
	localparam int T_DISC         = 0;         // disconnect hold-off
	localparam int T_RESP         = 1;         // selection answer window
	localparam int T_SELTO        = 2;         // selection time-out
	localparam int T_DEADL        = 3;         // power-up / reset deadline
	localparam int T_RSTH         = 4;         // reset drive hold
	localparam int N_TMR          = 5;
	localparam logic [CNT_W-1:0] GAP_RST = 8'hFF;   // gap counters start saturated

	typedef enum logic [3:0] {
		PH_BUSY   = 4'h1,   // bus in use, watching for idle
		PH_SETTLE = 4'h2,   // bsy and sel both low, settling
		PH_FREE   = 4'h4,   // bus free detected
		PH_ARB    = 4'h8    // own bsy and id asserted
	} sbpt_phase_t;

	typedef enum logic [2:0] {
		RATE_ASYNC  = 3'h0,
		RATE_FAST5  = 3'h1,
		RATE_FAST10 = 3'h2,
		RATE_FAST20 = 3'h3,
		RATE_FAST40 = 3'h4,
		RATE_FAST80 = 3'h5
	} sbpt_rate_t;

	typedef struct packed {
		logic bsy;      // busy
		logic sel;      // select
		logic rst;      // bus reset
		logic io;       // direction
		logic strobe;   // partner req or ack
	} sbpt_pins_t;

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             run;
		logic             done;
	} sbpt_tmr_t;

	typedef struct packed {
		sbpt_pins_t       sync1;      // first synchroniser stage
		sbpt_pins_t       sync2;      // second synchroniser stage
		sbpt_pins_t       prev;       // delayed copy for edges
		sbpt_phase_t      phase;
		logic [CNT_W-1:0] cnt;        // phase cycle counter
		logic [CNT_W-1:0] tx_gap;     // cycles since own strobe
		logic [CNT_W-1:0] rx_gap;     // cycles since partner strobe
		logic             rx_seen;
		logic             release_all;
		logic             arb_sample;
		logic             data_release;
		logic             strobe_fire;
		logic             strobe_err;
		logic             booted;
		logic             rst_req_prev;
	} sbpt_state_t;

	// transfer period in cycles, asynchronous has no spacing
	function automatic logic [CNT_W-1:0] sbpt_period_cyc(input sbpt_rate_t r);
		case (r)
			RATE_FAST5:  sbpt_period_cyc = CNT_W'(FAST5_NS / CLK_NS);
			RATE_FAST10: sbpt_period_cyc = CNT_W'(FAST10_NS / CLK_NS);
			RATE_FAST20: sbpt_period_cyc = CNT_W'(FAST20_NS / CLK_NS);
			RATE_FAST40: sbpt_period_cyc = CNT_W'(FAST40_NS / CLK_NS);
			RATE_FAST80: sbpt_period_cyc = CNT_W'(FAST80_NS / CLK_NS);
			default:     sbpt_period_cyc = 8'h01;
		endcase
	endfunction : sbpt_period_cyc

endpackage : sbpt_pkg

// File: rtl/sbpt_delay_timer.sv
// Purpose: loadable down counter for one long bus delay
// Assumes: load value of zero means no delay
// Notes:   run stays high exactly load_val cycles, done pulses after
`timescale 1ns/100ps
`default_nettype none
module sbpt_delay_timer (
	input  wire logic                      clk,       // core clock
	input  wire logic                      resetn,    // sync reset, low
	input  wire logic                      load,      // start the delay
	input  wire logic                      abort,     // stop, no done
	input  wire logic [sbpt_pkg::TMR_W-1:0] load_val, // delay in cycles
	output logic                           run,       // delay in progress
	output logic                           done       // one-cycle expiry
);

	// ************************************************************
	// state
	// ************************************************************
	sbpt_pkg::sbpt_tmr_t cur_reg;   // registered state
	sbpt_pkg::sbpt_tmr_t cur_next;  // next state

	// next-state logic, abort beats load
	always_comb
	begin
		cur_next      = cur_reg;
		cur_next.done = 1'b0;
		if (abort)
		begin
			cur_next.run = 1'b0;
			cur_next.cnt = '0;
		end
		else if (load)
		begin
			cur_next.cnt = load_val;
			cur_next.run = (load_val != '0);
		end
		else if (cur_reg.run)
		begin
			// last cycle of the delay
			if (cur_reg.cnt == sbpt_pkg::TMR_W'(1))
			begin
				cur_next.run  = 1'b0;
				cur_next.done = 1'b1;
			end
			cur_next.cnt = cur_reg.cnt - sbpt_pkg::TMR_W'(1);
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			cur_reg <= '0;
		else
			cur_reg <= cur_next;
	end

	assign run  = cur_reg.run;
	assign done = cur_reg.done;

endmodule : sbpt_delay_timer
`default_nettype wire

// File: rtl/sbpt_phase_timer.sv
// Purpose: protocol delay enforcement for a parallel bus device
// Assumes: bus pins are asynchronous, control inputs are on clk
// Notes:   releases are flagged one cycle after their trigger
// Overview of operation
// R1: wait arbitration delay before sampling the bus
// R2: bus free after bsy, sel idle settle delay
// R3: release all within clear delay of trigger
// R4: bus free release within 1200 ns of idle
// R5: slow detection shortens release window accordingly
// R6: wait bus free delay before arbitrating
// R7: arbitrate no later than bus set delay
// R8: initiator drops data soon after i/o rises
// R9: wait disconnection delay before rearbitrating
// R10: answer basic commands within ten seconds, recommended
// R11: strobe assertion edges spaced by transfer period
// R12: fastest supported rate timing always applies; code spaces strobes by the slower of rate_max and rate_neg
// R13: drive bus reset at least reset hold
// R14: no bsy answer after selection abort time
// R15: wait selection time-out before time-out procedure
// R16: delays are counters, minimum up, maximum down
// R17: bus reset aborts counters, returns to idle; code leaves the own reset hold timer running
`timescale 1ns/100ps
`default_nettype none
module sbpt_phase_timer #(
	parameter logic [31:0] DISC_CYC_P      = 32'(sbpt_pkg::DISC_CYC),
	parameter logic [31:0] SEL_ABORT_CYC_P = 32'(sbpt_pkg::SEL_ABORT_CYC),
	parameter logic [31:0] SEL_TMO_CYC_P   = 32'(sbpt_pkg::SEL_TMO_CYC),
	parameter logic [31:0] POWER_ON_CYC_P  = 32'(sbpt_pkg::POWER_ON_CYC),
	parameter logic [31:0] RESET_SEL_CYC_P = 32'(sbpt_pkg::RESET_SEL_CYC)
) (
	input  wire logic                 clk,            // 40 MHz
	input  wire logic                 resetn,         // sync reset, low
	input  wire sbpt_pkg::sbpt_pins_t bus_in,         // raw bus pins
	input  wire sbpt_pkg::sbpt_rate_t rate_max,       // fastest supported
	input  wire sbpt_pkg::sbpt_rate_t rate_neg,       // negotiated rate
	input  wire logic                 is_initiator,   // initiator role
	input  wire logic                 arb_request,    // wish to arbitrate
	input  wire logic                 disconnect,     // bsy freed for disconnect
	input  wire logic                 selected,       // selection detected
	input  wire logic                 bsy_response,   // own bsy answer given
	input  wire logic                 sel_start,      // own selection begun
	input  wire logic                 strobe_request, // want a strobe edge
	input  wire logic                 rst_request,    // want bus reset
	output logic                      bus_free,       // bus free phase
	output logic                      release_all,    // release every signal
	output logic                      arb_assert,     // drive bsy and own id
	output logic                      arb_sample,     // evaluate arbitration
	output logic                      data_release,   // drop data bus
	output logic                      resp_allow,     // bsy answer allowed
	output logic                      sel_timeout,    // selection timed out
	output logic                      ready_deadline, // answer deadline reached
	output logic                      disc_holdoff,   // arbitration blocked
	output logic                      strobe_fire,    // assert strobe now
	output logic                      strobe_err,     // partner strobe too soon
	output logic                      rst_oe          // drive bus reset
);

	// ************************************************************
	// state and timer wiring
	// ************************************************************
	localparam int CNT_W = sbpt_pkg::CNT_W;                            // counter width
	localparam logic [sbpt_pkg::CNT_W-1:0] GAP_MAX = sbpt_pkg::GAP_RST; // saturation
	sbpt_pkg::sbpt_state_t s_reg;                      // all state
	sbpt_pkg::sbpt_state_t s_next;                     // next state
	logic [sbpt_pkg::N_TMR-1:0]              t_load;   // timer starts
	logic [sbpt_pkg::N_TMR-1:0]              t_abort;  // timer stops
	logic [sbpt_pkg::N_TMR-1:0]              t_run;    // timer busy
	logic [sbpt_pkg::N_TMR-1:0]              t_done;   // timer expiry
	logic [sbpt_pkg::TMR_W-1:0]              t_val [sbpt_pkg::N_TMR];
	logic                                    rst_s;    // synced reset pin
	logic                                    idle_s;   // bsy and sel low
	logic                                    bsy_rise; // bsy answer seen
	logic                                    io_rise;  // i/o false to true
	logic                                    rx_rise;  // partner strobe edge
	logic [sbpt_pkg::CNT_W-1:0]              period;   // strobe spacing

	// decoded synchronised pins
	assign rst_s    = s_reg.sync2.rst;
	assign idle_s   = !s_reg.sync2.bsy && !s_reg.sync2.sel;
	assign bsy_rise = s_reg.sync2.bsy && !s_reg.prev.bsy;
	assign io_rise  = s_reg.sync2.io && !s_reg.prev.io;
	assign rx_rise  = s_reg.sync2.strobe && !s_reg.prev.strobe;

	// spacing never shorter than the fastest supported rate allows
	always_comb
	begin
		if (sbpt_pkg::sbpt_period_cyc(rate_neg) > sbpt_pkg::sbpt_period_cyc(rate_max)) // [R12]
			period = sbpt_pkg::sbpt_period_cyc(rate_neg);
		else
			period = sbpt_pkg::sbpt_period_cyc(rate_max);
	end

	// ************************************************************
	// long delay timers
	// ************************************************************
	always_comb
	begin
		// disconnect hold-off, minimum delay
		t_load[sbpt_pkg::T_DISC]   = disconnect;                      // [R9]
		t_abort[sbpt_pkg::T_DISC]  = rst_s;                           // [R17]
		t_val[sbpt_pkg::T_DISC]    = DISC_CYC_P;
		// selection answer window, maximum delay
		t_load[sbpt_pkg::T_RESP]   = selected;                        // [R14]
		t_abort[sbpt_pkg::T_RESP]  = rst_s || bsy_response;
		t_val[sbpt_pkg::T_RESP]    = SEL_ABORT_CYC_P;
		// selection time-out, ended by a bsy answer
		t_load[sbpt_pkg::T_SELTO]  = sel_start;                       // [R15]
		t_abort[sbpt_pkg::T_SELTO] = rst_s || bsy_rise;
		t_val[sbpt_pkg::T_SELTO]   = SEL_TMO_CYC_P;
		// answer deadline after power-up or after a bus reset
		t_load[sbpt_pkg::T_DEADL]  = !s_reg.booted || (!rst_s && s_reg.prev.rst); // [R10]
		t_abort[sbpt_pkg::T_DEADL] = rst_s;
		t_val[sbpt_pkg::T_DEADL]   = s_reg.booted ? RESET_SEL_CYC_P : POWER_ON_CYC_P;
		// own reset drive, never cut short by the bus reset it makes
		t_load[sbpt_pkg::T_RSTH]   = rst_request && !s_reg.rst_req_prev
			&& !t_run[sbpt_pkg::T_RSTH];                              // [R13]
		t_abort[sbpt_pkg::T_RSTH]  = 1'b0;
		t_val[sbpt_pkg::T_RSTH]    = 32'(sbpt_pkg::RESET_HOLD_CYC);
	end

	// one counter per timer index, power-up and bus reset deadlines share one
	generate
		for (genvar i = 0; i < sbpt_pkg::N_TMR; i++)
		begin : g_tmr
			sbpt_delay_timer u_tmr (
				.clk      (clk),
				.resetn   (resetn),
				.load     (t_load[i]),
				.abort    (t_abort[i]),
				.load_val (t_val[i]),
				.run      (t_run[i]),
				.done     (t_done[i])
			);                                                        // [R16]
		end
	endgenerate

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb
	begin
		s_next              = s_reg;
		s_next.sync1        = bus_in;
		s_next.sync2        = s_reg.sync1;
		s_next.prev         = s_reg.sync2;
		s_next.booted       = 1'b1;
		s_next.rst_req_prev = rst_request;
		s_next.release_all  = 1'b0;
		s_next.arb_sample   = 1'b0;
		s_next.strobe_fire  = 1'b0;
		s_next.strobe_err   = 1'b0;
		// initiator leaves the data bus on i/o rise
		s_next.data_release = is_initiator && io_rise;                // [R8]

		// own strobe spacing
		if (strobe_request && s_reg.tx_gap >= period)                 // [R11]
		begin
			s_next.strobe_fire = 1'b1;
			s_next.tx_gap      = 8'h01;
		end
		else if (s_reg.tx_gap != GAP_MAX)
			s_next.tx_gap = s_reg.tx_gap + 8'h01;

		// partner strobe spacing check
		if (rx_rise)
		begin
			s_next.strobe_err = s_reg.rx_seen && (s_reg.rx_gap < period); // [R11]
			s_next.rx_gap     = 8'h01;
			s_next.rx_seen    = 1'b1;
		end
		else if (s_reg.rx_gap != GAP_MAX)
			s_next.rx_gap = s_reg.rx_gap + 8'h01;

		if (rst_s)
		begin
			// bus reset: release, drop arbitration, back to watching
			s_next.release_all = 1'b1;                                // [R3]
			s_next.phase       = sbpt_pkg::PH_BUSY;                   // [R17]
			s_next.cnt         = '0;
			s_next.rx_seen     = 1'b0;
		end
		else
		begin
			case (s_reg.phase)
				sbpt_pkg::PH_BUSY:
				begin
					// first idle cycle starts the settle count
					if (idle_s)
					begin
						s_next.phase = sbpt_pkg::PH_SETTLE;
						s_next.cnt   = 8'h01;
					end
				end
				sbpt_pkg::PH_SETTLE:
				begin
					if (!idle_s)
						s_next.phase = sbpt_pkg::PH_BUSY;
					else if (s_reg.cnt >= CNT_W'(sbpt_pkg::SETTLE_CYC)) // [R2]
					begin
						// detection on time, so release needs no shortening
						s_next.phase       = sbpt_pkg::PH_FREE;
						s_next.release_all = 1'b1;                    // [R3] [R4] [R5]
						s_next.cnt         = 8'h01;
					end
					else
						s_next.cnt = s_reg.cnt + 8'h01;
				end
				sbpt_pkg::PH_FREE:
				begin
					// a winner's sel ends the phase; so does a missed window
					if (s_reg.sync2.sel || s_reg.cnt >= CNT_W'(sbpt_pkg::BUS_SET_CYC))
						s_next.phase = sbpt_pkg::PH_BUSY;
					else if (arb_request && !t_run[sbpt_pkg::T_DISC]   // [R9]
						&& s_reg.cnt >= CNT_W'(sbpt_pkg::BUS_FREE_CYC)) // [R6] [R7]
					begin
						s_next.phase = sbpt_pkg::PH_ARB;
						s_next.cnt   = 8'h01;
					end
					else
						s_next.cnt = s_reg.cnt + 8'h01;
				end
				sbpt_pkg::PH_ARB:
				begin
					if (s_reg.sync2.sel)
					begin
						// another device selects: back off at once
						s_next.phase       = sbpt_pkg::PH_BUSY;
						s_next.release_all = 1'b1;                    // [R3]
					end
					else if (s_reg.cnt >= CNT_W'(sbpt_pkg::ARB_CYC))  // [R1]
					begin
						s_next.phase      = sbpt_pkg::PH_BUSY;
						s_next.arb_sample = 1'b1;
					end
					else
						s_next.cnt = s_reg.cnt + 8'h01;
				end
				default:
				begin
					s_next.phase = sbpt_pkg::PH_BUSY;
					s_next.cnt   = '0;
				end
			endcase
		end
	end

	// state register, constants only under reset
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s_reg        <= '0;
			s_reg.phase  <= sbpt_pkg::PH_BUSY;
			s_reg.tx_gap <= sbpt_pkg::GAP_RST;
			s_reg.rx_gap <= sbpt_pkg::GAP_RST;
		end
		else
			s_reg <= s_next;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign bus_free       = (s_reg.phase == sbpt_pkg::PH_FREE);
	assign arb_assert     = (s_reg.phase == sbpt_pkg::PH_ARB);
	assign release_all    = s_reg.release_all;
	assign arb_sample     = s_reg.arb_sample;
	assign data_release   = s_reg.data_release;
	assign strobe_fire    = s_reg.strobe_fire;
	assign strobe_err     = s_reg.strobe_err;
	assign disc_holdoff   = t_run[sbpt_pkg::T_DISC];
	assign resp_allow     = t_run[sbpt_pkg::T_RESP];
	assign sel_timeout    = t_done[sbpt_pkg::T_SELTO];
	assign ready_deadline = t_done[sbpt_pkg::T_DEADL];
	assign rst_oe         = rst_request || t_run[sbpt_pkg::T_RSTH];

	// ************************************************************
	// assertion helpers
	// ************************************************************
	logic [15:0] arb_age;    // cycles of own arbitration drive
	logic [15:0] free_age;   // cycles since bus free detection
	logic [15:0] idle_age;   // idle cycles since settle began
	logic [15:0] rst_age;    // cycles of reset drive

	// helper counters, read only by assertions
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			arb_age  <= 16'h0000;
			free_age <= 16'h0000;
			idle_age <= 16'h0000;
			rst_age  <= 16'h0000;
		end
		else
		begin
			arb_age  <= arb_assert ? arb_age + 16'h0001 : (arb_sample ? arb_age : 16'h0000);
			free_age <= bus_free ? free_age + 16'h0001 : 16'h0000;
			idle_age <= !idle_s ? 16'h0000 :
				((s_reg.phase == sbpt_pkg::PH_BUSY) ? 16'h0001 : idle_age + 16'h0001);
			rst_age  <= rst_oe ? rst_age + 16'h0001 : 16'h0000;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	a_arb_sample_late: assert property (@(posedge clk) disable iff (!resetn) // [R1]
		arb_sample |-> arb_age >= 16'(sbpt_pkg::ARB_CYC))
		else $error("arbitration sampled too early");

	a_free_settled: assert property (@(posedge clk) disable iff (!resetn) // [R2]
		$rose(bus_free) |-> $past(idle_age) >= 16'(sbpt_pkg::SETTLE_CYC - 1))
		else $error("bus free without full settle");

	a_free_release: assert property (@(posedge clk) disable iff (!resetn) // [R4]
		$rose(bus_free) |-> release_all && idle_age <= 16'(sbpt_pkg::FREE_REL_CYC))
		else $error("bus free release late");

	a_sel_backoff: assert property (@(posedge clk) disable iff (!resetn) // [R3]
		(arb_assert && s_reg.sync2.sel && !rst_s) |=> release_all && !arb_assert)
		else $error("no release on foreign sel");

	a_rst_abort: assert property (@(posedge clk) disable iff (!resetn) // [R17]
		rst_s |=> release_all && !arb_assert && !bus_free && !disc_holdoff)
		else $error("bus reset did not abort");

	a_arb_window: assert property (@(posedge clk) disable iff (!resetn) // [R6]
		$rose(arb_assert) |-> free_age >= 16'(sbpt_pkg::BUS_FREE_CYC)
			&& free_age <= 16'(sbpt_pkg::BUS_SET_CYC) && !$past(disc_holdoff))
		else $error("arbitration outside window");

	a_data_drop: assert property (@(posedge clk) disable iff (!resetn) // [R8]
		(io_rise && is_initiator) |-> ##1 data_release)
		else $error("data bus not released");

	a_strobe_space: assert property (@(posedge clk) disable iff (!resetn) // [R11]
		strobe_fire |=> !strobe_fire || period == 8'h01)
		else $error("strobe edges too close");

	a_rst_hold: assert property (@(posedge clk) disable iff (!resetn) // [R13]
		$fell(rst_oe) |-> rst_age >= 16'(sbpt_pkg::RESET_HOLD_CYC))
		else $error("reset drive too short");

	a_resp_window: assert property (@(posedge clk) disable iff (!resetn) // [R14]
		$rose(selected) && !rst_s |=> resp_allow)
		else $error("answer window not opened");

endmodule : sbpt_phase_timer
`default_nettype wire

// File: tb/sbpt_tb_partner.sv
// Purpose: far side devices driving the shared control lines
// Assumes: requests change at falling edges, lines move at rising edges
// Notes:   a reset request is stretched to the reset hold time
`timescale 1ns/100ps
`default_nettype none
module sbpt_tb_partner (
	input  wire logic           clk,  // core clock
	input  wire logic [4:0]     want, // requested bsy, sel, rst, io, strobe
	output var sbpt_pkg::sbpt_pins_t pins  // lines as driven
);
	int hold_cnt; // reset drive cycles left
	initial pins = '0;
	initial hold_cnt = 0;
	// ************************************************************
	// line drive
	// ************************************************************
	always @(posedge clk)
	begin
		hold_cnt <= want[2] ? sbpt_pkg::RESET_HOLD_CYC : (hold_cnt > 0 ? hold_cnt - 1 : 0);
		pins <= {want[4:3], want[2] || hold_cnt > 1, want[1:0]};
	end
endmodule : sbpt_tb_partner
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench for the bus phase timer
// Assumes: long delays shortened by parameters
// Notes:   latencies are counted in cycles against their bounds
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ************************************************************
	// stimulus, model and checks
	// ************************************************************
	logic clk = 0, resetn = 0, is_i = 0, arq = 0, dsc = 0, sp = 0, ss = 0, sq = 0, rq = 0;
	logic br = 0;             // bsy answer pulse
	logic [4:0] want = 5'h10; // partner requests, bus busy
	wire logic [11:0] o;      // outputs, bus_free on top
	sbpt_pkg::sbpt_pins_t pins;
	sbpt_pkg::sbpt_rate_t rm = sbpt_pkg::RATE_FAST5, rn = sbpt_pkg::RATE_FAST5;
	int mismatches = 0, num_checks = 0, n, k, e, j, seed = 32'hC1B51B03;
	sbpt_tb_partner sbpt_tb_partner_inst (.clk(clk), .want(want), .pins(pins));
	sbpt_phase_timer #(.DISC_CYC_P(32'h14), .SEL_ABORT_CYC_P(32'h1E), .SEL_TMO_CYC_P(32'h28),
		.POWER_ON_CYC_P(32'h32), .RESET_SEL_CYC_P(32'h32)) sbpt_phase_timer_inst (
		.clk(clk), .resetn(resetn), .bus_in(pins), .rate_max(rm), .rate_neg(rn),
		.is_initiator(is_i), .arb_request(arq), .disconnect(dsc), .selected(sp),
		.bsy_response(br), .sel_start(ss), .strobe_request(sq), .rst_request(rq),
		.bus_free(o[11]), .release_all(o[10]), .arb_assert(o[9]), .arb_sample(o[8]),
		.data_release(o[7]), .resp_allow(o[6]), .sel_timeout(o[5]), .ready_deadline(o[4]),
		.disc_holdoff(o[3]), .strobe_fire(o[2]), .strobe_err(o[1]), .rst_oe(o[0]));
	// cycles until output i shows v, lim if never
	task automatic wt(input int i, input logic v, input int lim);
		n = 0;
		while (o[i] !== v && n < lim)
		begin
			@(negedge clk);
			n++;
		end
	endtask : wt
	task automatic chk(input int got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask : chk
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge clk);
		s = 0;
	endtask : pulse
	// strobe period in cycles per rate, rounded up
	function automatic int per(input int r);
		int ns[6] = '{25, 200, 100, 50, 25, 25};
		return (ns[r] + 24) / 25;
	endfunction : per
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	initial forever #12.5 clk = ~clk;
	// watchdog well past the expected run
	initial
	begin
		#400000;
		mismatches++;
		print_verdict();
	end
	initial
	begin
		repeat (20) @(negedge clk);
		resetn = 1;
		for (k = 0; k < 2; k++)
		begin
			want = 5'h10;
			arq = 1;
			repeat (8) @(negedge clk);
			want = 5'h00;
			wt(11, 1, 100);
			chk(n, sbpt_pkg::SETTLE_CYC, sbpt_pkg::FREE_REL_CYC);
			wt(10, 1, 1);
			chk(n, 0, 0);
			wt(9, 1, 100);
			chk(n, sbpt_pkg::BUS_FREE_CYC - 1, sbpt_pkg::BUS_SET_CYC);
			want = k ? 5'h08 : 5'h00; // foreign select in the second round
			wt(k ? 10 : 8, 1, 200);
			chk(n, k ? 0 : sbpt_pkg::ARB_CYC, k ? sbpt_pkg::BUS_CLEAR_CYC : 100);
			$display("arbitration test %0d done", k);
		end
		arq = 0;
		is_i = 1;
		want = 5'h00;
		repeat (4) @(negedge clk);
		want = 5'h02;
		wt(7, 1, 40);
		chk(n, 1, sbpt_pkg::DATA_REL_CYC);
		for (k = 0; k < 4; k++)
		begin
			rm = sbpt_pkg::sbpt_rate_t'(3'($unsigned($random(seed)) % 6));
			rn = sbpt_pkg::sbpt_rate_t'(3'($unsigned($random(seed)) % 6));
			e = per(rm) > per(rn) ? per(rm) : per(rn);
			sq = 1;
			wt(2, 1, 20);
			for (j = 0; j < 3; j++)
			begin
				@(negedge clk);
				wt(2, 1, 20);
				chk(n + 1, e, e + 2);
			end
			sq = 0;
			repeat (10) @(negedge clk);
		end
		// partner strobe edges two cycles apart, then well spaced
		rm = sbpt_pkg::RATE_FAST5;
		rn = sbpt_pkg::RATE_FAST5;
		want = 5'h03;
		@(negedge clk);
		want = 5'h02;
		@(negedge clk);
		want = 5'h03;
		wt(1, 1, 10);
		chk(n, 4, 4);
		want = 5'h02;
		repeat (10) @(negedge clk);
		want = 5'h03;
		wt(1, 1, 8);
		chk(n, 8, 8);
		$display("strobe and data test done");
		pulse(dsc);
		wt(3, 0, 100);
		chk(n, 20, 22);
		pulse(sp);
		wt(6, 0, 100);
		chk(n, 25, 30);
		pulse(sp);
		wt(6, 1, 2);
		chk(n, 0, 0);
		pulse(br);
		wt(6, 0, 2);
		chk(n, 0, 0);
		pulse(ss);
		wt(5, 1, 100);
		chk(n, 40, 43);
		pulse(rq);
		wt(0, 0, 1100);
		chk(n, sbpt_pkg::RESET_HOLD_CYC, sbpt_pkg::RESET_HOLD_CYC + 3);
		want = 5'h04;
		repeat (5) @(negedge clk);
		wt(10, 1, 1);
		chk(n, 0, 0);
		wt(11, 1, 1);
		chk(n, 1, 1);
		// drop bus reset, answer deadline follows its synced end
		want = 5'h00;
		wt(10, 0, 1100);
		wt(4, 1, 60);
		chk(n, 50, 51);
		$display("timer and reset test done");
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
